// ---- serial_pkg.sv ----
package serial_pkg;

   ////////////////////////////////////////////////////////////////////////
   // frame layout
   localparam int ADDR_W     = 12;
   localparam int DATA_W     = 28;
   localparam logic [5:0] FRAME_BITS = 6'h28;
   localparam logic [5:0] WORD_BITS  = 6'h1c;
   localparam logic [4:0] ADDR_LAST_BIT = 5'h0b;
   localparam logic [4:0] DATA_LAST_BIT = 5'h1b;

   ////////////////////////////////////////////////////////////////////////
   // address map
   localparam logic [11:0] FIXED_LAST      = 12'h091;
   localparam logic [11:0] TABLE_BASE      = 12'h400;
   localparam logic [11:0] LINE_DELAY_ADDR = 12'h018;
   localparam logic [11:0] PG_COUNT_ADDR   = 12'h090;
   localparam logic [11:0] SEQ_COUNT_ADDR  = 12'h091;
   localparam logic [11:0] SCK_LAST        = 12'h003;
   localparam logic [11:0] SG_FIRST        = 12'h070;
   localparam logic [11:0] SG_LAST         = 12'h07f;
   localparam logic [11:0] PG_SIZE         = 12'h028;
   localparam logic [11:0] SEQ_SIZE        = 12'h014;
   localparam logic [11:0] FIELD_SIZE      = 12'h00c;
   localparam logic [11:0] ADDR_TOP        = 12'hfff;
   localparam logic [27:0] REG_RESET       = 28'h0000000;

   typedef enum logic [2:0] {
      CL_NONE, CL_SCK, CL_VD, CL_SG, CL_PAT, CL_SEQ, CL_FIELD
   } reg_class_e;

   ////////////////////////////////////////////////////////////////////////
   // host timing and register port
   localparam int CLK_HZ  = 50_000_000;
   localparam int SCLK_HZ = 3_125_000;
   localparam logic [3:0] HALF_CYCLES = 4'(CLK_HZ / (2 * SCLK_HZ));
   localparam logic [3:0] HOST_ADDR_REG   = 4'h0;
   localparam logic [3:0] HOST_DATA_REG   = 4'h4;
   localparam logic [3:0] HOST_CTRL_REG   = 4'h8;
   localparam logic [3:0] HOST_STATUS_REG = 4'hc;

endpackage

// ---- serial_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface serial_link_if;
   logic sclk;
   logic sdata;
   logic serial_load_strobe_n;

   modport device (input sclk, input sdata, input serial_load_strobe_n);
   modport host   (output sclk, output sdata, output serial_load_strobe_n);
endinterface
`default_nettype wire

// ---- serial_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module serial_host (
   input  wire logic        clk,
   input  wire logic        rst_n,
   serial_link_if.host      link,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata
);
   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_HOLD} host_state_e;

   host_state_e  state;
   logic [11:0]  start_addr;
   logic [39:0]  shreg;
   logic [5:0]   bits_left;
   logic [3:0]   phase;
   logic         sclk_q;
   logic         strobe_n;
   logic         end_req;

   logic data_wr;
   logic end_wr;
   assign data_wr = reg_wr && reg_addr == serial_pkg::HOST_DATA_REG;
   assign end_wr  = reg_wr && reg_addr == serial_pkg::HOST_CTRL_REG && reg_wdata[0];

   assign link.sclk                 = sclk_q;
   assign link.sdata                = shreg[0];
   assign link.serial_load_strobe_n = strobe_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_addr <= 12'h000;
      end else if (reg_wr && reg_addr == serial_pkg::HOST_ADDR_REG) begin
         start_addr <= reg_wdata[11:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shifter: data changes while sclk is low, device samples on the rise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= H_IDLE;
         shreg     <= 40'h0000000000;
         bits_left <= 6'h00;
         phase     <= 4'h0;
         sclk_q    <= 1'b0;
         strobe_n  <= 1'b1;
         end_req   <= 1'b0;
      end else begin
         case (state)
            H_IDLE: begin
               if (data_wr) begin
                  shreg     <= {reg_wdata[27:0], start_addr};
                  bits_left <= serial_pkg::FRAME_BITS;
                  phase     <= 4'h0;
                  strobe_n  <= 1'b0;
                  end_req   <= 1'b0;
                  state     <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (end_wr) begin
                  end_req <= 1'b1;
               end
               if (phase == serial_pkg::HALF_CYCLES - 4'h1) begin
                  phase  <= 4'h0;
                  sclk_q <= ~sclk_q;
                  if (sclk_q) begin
                     shreg     <= {1'b0, shreg[39:1]};
                     bits_left <= bits_left - 6'h01;
                     if (bits_left == 6'h01) begin
                        if (end_req || end_wr) begin
                           strobe_n <= 1'b1;
                           state    <= H_IDLE;
                        end else begin
                           state <= H_HOLD;
                        end
                     end
                  end
               end else begin
                  phase <= phase + 4'h1;
               end
            end
            H_HOLD: begin
               if (end_wr) begin
                  strobe_n <= 1'b1;
                  state    <= H_IDLE;
               end else if (data_wr) begin
                  shreg     <= {12'h000, reg_wdata[27:0]};
                  bits_left <= serial_pkg::WORD_BITS;
                  phase     <= 4'h0;
                  end_req   <= 1'b0;
                  state     <= H_SHIFT;
               end
            end
            default: begin
               state    <= H_IDLE;
               strobe_n <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd && reg_addr == serial_pkg::HOST_STATUS_REG) begin
         reg_rdata <= {29'h00000000, end_req, !strobe_n, state == H_SHIFT};
      end else if (reg_rd && reg_addr == serial_pkg::HOST_ADDR_REG) begin
         reg_rdata <= {20'h00000, start_addr};
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// ---- serial_device.sv ----
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module serial_device (
   input  wire logic        clk,
   input  wire logic        rst_n,
   serial_link_if.device    link,
   input  wire logic        vertical_sync,
   input  wire logic        horizontal_sync,
   input  wire logic        sensor_gate,
   input  wire logic        sequence_change_position,
   input  wire logic [7:0]  scp_sequence,
   input  wire logic [7:0]  scp_pattern_group,
   input  wire logic [11:0] rd_addr,
   input  wire logic        rd_strobe,
   output logic      [27:0] rd_data,
   output logic             frame_written,
   output logic             frame_discarded,
   output logic             commit_busy
);
   typedef enum logic {SW_IDLE, SW_RUN} sweep_state_e;

   logic [2:0]   sync1;
   logic [2:0]   sync2;
   logic [2:0]   sync3;
   logic         sclk_rise;
   logic         strobe_low;
   logic         in_data;
   logic [4:0]   bit_cnt;
   logic [11:0]  addr_sh;
   logic [27:0]  data_sh;
   logic [11:0]  cur_addr;
   logic         wr_en;
   logic [11:0]  wr_addr;
   logic [27:0]  wr_data;

   logic [27:0]  active [0:4095];
   logic [27:0]  shadow [0:4095];
   logic [4095:0] pending;

   logic [11:0]  seq_base;
   logic [11:0]  field_base;
   serial_pkg::reg_class_e wr_cls;
   serial_pkg::reg_class_e sw_cls;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; only the second stage and later are read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 3'h4;
         sync2 <= 3'h4;
         sync3 <= 3'h4;
      end else begin
         sync1 <= {link.serial_load_strobe_n, link.sdata, link.sclk};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   assign sclk_rise  = sync2[0] && !sync3[0];
   assign strobe_low = !sync2[2];

   ////////////////////////////////////////////////////////////////////////
   // frame assembly
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_data         <= 1'b0;
         bit_cnt         <= 5'h00;
         addr_sh         <= 12'h000;
         data_sh         <= 28'h0000000;
         cur_addr        <= 12'h000;
         wr_en           <= 1'b0;
         wr_addr         <= 12'h000;
         wr_data         <= 28'h0000000;
         frame_discarded <= 1'b0;
      end else begin
         wr_en           <= 1'b0;
         frame_discarded <= 1'b0;
         if (!strobe_low) begin
            // a word cut short never reaches wr_en
            frame_discarded <= in_data && bit_cnt != 5'h00 || !in_data && bit_cnt != 5'h00;
            in_data <= 1'b0;
            bit_cnt <= 5'h00;
         end else if (sclk_rise) begin
            if (!in_data) begin
               addr_sh <= {sync2[1], addr_sh[11:1]};
               if (bit_cnt == serial_pkg::ADDR_LAST_BIT) begin
                  cur_addr <= {sync2[1], addr_sh[11:1]};
                  in_data  <= 1'b1;
                  bit_cnt  <= 5'h00;
               end else begin
                  bit_cnt <= bit_cnt + 5'h01;
               end
            end else begin
               data_sh <= {sync2[1], data_sh[27:1]};
               if (bit_cnt == serial_pkg::DATA_LAST_BIT) begin
                  wr_en    <= 1'b1;
                  wr_addr  <= cur_addr;
                  wr_data  <= {sync2[1], data_sh[27:1]};
                  cur_addr <= cur_addr + 12'h001;
                  bit_cnt  <= 5'h00;
               end else begin
                  bit_cnt <= bit_cnt + 5'h01;
               end
            end
         end
      end
   end
   assign frame_written = wr_en;

   ////////////////////////////////////////////////////////////////////////
   // address classification
   assign seq_base   = serial_pkg::TABLE_BASE
                     + 12'(active[serial_pkg::PG_COUNT_ADDR][7:0] * serial_pkg::PG_SIZE);
   assign field_base = seq_base
                     + 12'(active[serial_pkg::SEQ_COUNT_ADDR][7:0] * serial_pkg::SEQ_SIZE);

   function automatic serial_pkg::reg_class_e classify(input logic [11:0] a,
                                                      input logic [11:0] sb,
                                                      input logic [11:0] fb);
      serial_pkg::reg_class_e c;
      c = serial_pkg::CL_NONE;
      if (a <= serial_pkg::FIXED_LAST) begin
         if (a <= serial_pkg::SCK_LAST || a == serial_pkg::PG_COUNT_ADDR
             || a == serial_pkg::SEQ_COUNT_ADDR) begin
            c = serial_pkg::CL_SCK;
         end else if (a >= serial_pkg::SG_FIRST && a <= serial_pkg::SG_LAST) begin
            c = serial_pkg::CL_SG;
         end else begin
            c = serial_pkg::CL_VD;
         end
      end else if (a >= serial_pkg::TABLE_BASE) begin
         if (a < sb) begin
            c = serial_pkg::CL_PAT;
         end else if (a < fb) begin
            c = serial_pkg::CL_SEQ;
         end else begin
            c = serial_pkg::CL_FIELD;
         end
      end
      return c;
   endfunction

   assign wr_cls = classify(wr_addr, seq_base, field_base);

   ////////////////////////////////////////////////////////////////////////
   // commit events; a new event in the cycle a sweep takes the old one stays pending for the next sweep
   logic        vs_q;
   logic        hs_q;
   logic        vs_fall;
   logic        hs_fall;
   logic        gate_line;
   logic        delay_run;
   logic [27:0] line_cnt;
   logic        req_vd;
   logic        req_field;
   logic        req_sg;
   logic        req_scp;
   logic [7:0]  req_seq;
   logic [7:0]  req_pg;
   logic        vd_event;
   logic        take;
   logic [27:0] line_delay;

   // own copy of the delay register: the array has no reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_delay <= serial_pkg::REG_RESET;
      end else if (sw_copy && sw_addr == serial_pkg::LINE_DELAY_ADDR) begin
         line_delay <= shadow[sw_addr];
      end
   end

   assign vs_fall = vs_q && !vertical_sync;
   assign hs_fall = hs_q && !horizontal_sync;
   assign vd_event = vs_fall && line_delay == 28'h0000000
                  || delay_run && hs_fall && line_cnt + 28'h0000001 >= line_delay;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vs_q      <= 1'b0;
         hs_q      <= 1'b0;
         gate_line <= 1'b0;
         delay_run <= 1'b0;
         line_cnt  <= 28'h0000000;
      end else begin
         vs_q <= vertical_sync;
         hs_q <= horizontal_sync;
         if (hs_fall) begin
            gate_line <= sensor_gate;
         end else if (sensor_gate) begin
            gate_line <= 1'b1;
         end
         if (vs_fall) begin
            delay_run <= line_delay != 28'h0000000;
            line_cnt  <= 28'h0000000;
         end else if (vd_event) begin
            delay_run <= 1'b0;
         end else if (delay_run && hs_fall) begin
            line_cnt <= line_cnt + 28'h0000001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_vd    <= 1'b0;
         req_field <= 1'b0;
         req_sg    <= 1'b0;
         req_scp   <= 1'b0;
         req_seq   <= 8'h00;
         req_pg    <= 8'h00;
      end else begin
         req_vd    <= vd_event || req_vd && !take;
         req_field <= vs_fall || req_field && !take;
         req_sg    <= hs_fall && (gate_line || sensor_gate) || req_sg && !take;
         req_scp   <= sequence_change_position || req_scp && !take;
         if (sequence_change_position) begin
            req_seq <= scp_sequence;
            req_pg  <= scp_pattern_group;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // commit sweep: walks every address once and copies matching pending words
   sweep_state_e sw_state;
   logic [11:0]  sw_addr;
   logic [7:0]   unit_cnt;
   logic [11:0]  off_cnt;
   logic         t_vd;
   logic         t_field;
   logic         t_sg;
   logic         t_scp;
   logic [7:0]   t_seq;
   logic [7:0]   t_pg;
   logic         sw_match;
   logic         sw_copy;
   logic [11:0]  sw_next;
   logic [11:0]  unit_size;

   assign take    = sw_state == SW_IDLE && (req_vd || req_field || req_sg || req_scp);
   assign sw_cls  = classify(sw_addr, seq_base, field_base);
   assign sw_next = sw_addr + 12'h001;
   assign unit_size = sw_cls == serial_pkg::CL_PAT ? serial_pkg::PG_SIZE
                    : sw_cls == serial_pkg::CL_SEQ ? serial_pkg::SEQ_SIZE
                    : serial_pkg::FIELD_SIZE;
   assign sw_match = sw_cls == serial_pkg::CL_VD && t_vd
                  || sw_cls == serial_pkg::CL_FIELD && t_field
                  || sw_cls == serial_pkg::CL_SG && t_sg
                  || sw_cls == serial_pkg::CL_SEQ && t_scp && unit_cnt == t_seq
                  || sw_cls == serial_pkg::CL_PAT && t_scp && unit_cnt == t_pg;
   assign sw_copy = sw_state == SW_RUN && pending[sw_addr] && sw_match;
   assign commit_busy = sw_state == SW_RUN;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_state <= SW_IDLE;
         sw_addr  <= 12'h000;
         unit_cnt <= 8'h00;
         off_cnt  <= 12'h000;
         t_vd     <= 1'b0;
         t_field  <= 1'b0;
         t_sg     <= 1'b0;
         t_scp    <= 1'b0;
         t_seq    <= 8'h00;
         t_pg     <= 8'h00;
      end else begin
         case (sw_state)
            SW_IDLE: begin
               if (take) begin
                  {t_vd, t_field, t_sg, t_scp} <= {req_vd, req_field, req_sg, req_scp};
                  t_seq    <= req_seq;
                  t_pg     <= req_pg;
                  sw_addr  <= 12'h000;
                  sw_state <= SW_RUN;
               end
            end
            SW_RUN: begin
               sw_addr <= sw_next;
               if (sw_next == serial_pkg::TABLE_BASE || sw_next == seq_base
                   || sw_next == field_base) begin
                  unit_cnt <= 8'h00;
                  off_cnt  <= 12'h000;
               end else if (off_cnt == unit_size - 12'h001) begin
                  unit_cnt <= unit_cnt + 8'h01;
                  off_cnt  <= 12'h000;
               end else begin
                  off_cnt <= off_cnt + 12'h001;
               end
               if (sw_addr == serial_pkg::ADDR_TOP) begin
                  sw_state <= SW_IDLE;
               end
            end
            default: sw_state <= SW_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // storage; a later write overwrites the shadow, so only the newest commits
   always_ff @(posedge clk) begin
      if (wr_en && wr_cls == serial_pkg::CL_SCK) begin
         active[wr_addr] <= wr_data;
      end
      if (sw_copy) begin
         active[sw_addr] <= shadow[sw_addr];
      end
   end

   always_ff @(posedge clk) begin
      if (wr_en && wr_cls != serial_pkg::CL_NONE && wr_cls != serial_pkg::CL_SCK) begin
         shadow[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= '0;
      end else begin
         if (sw_copy) begin
            pending[sw_addr] <= 1'b0;
         end
         if (wr_en && wr_cls != serial_pkg::CL_NONE && wr_cls != serial_pkg::CL_SCK) begin
            pending[wr_addr] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= serial_pkg::REG_RESET;
      end else if (rd_strobe) begin
         rd_data <= active[rd_addr];
      end
   end
endmodule
`default_nettype wire

// ---- serial_link_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module serial_link_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic sdata,
   input wire logic serial_load_strobe_n
);
   logic       strobe_q;
   logic       sclk_q;
   logic [9:0] rises;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////
   // rises of sclk since the strobe fell, cleared at each new frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_q <= 1'b1;
         sclk_q   <= 1'b0;
         rises    <= 10'h000;
      end else begin
         strobe_q <= serial_load_strobe_n;
         sclk_q   <= sclk;
         if (strobe_q && !serial_load_strobe_n) begin
            rises <= 10'h000;
         end else if (sclk && !sclk_q) begin
            rises <= rises + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   chk_idle_sclk_low: assert property (serial_load_strobe_n |-> !sclk)
      else $error("sclk high while strobe released");
   chk_sclk_high_len: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("sclk high phase not eight cycles");
   chk_sclk_low_len: assert property ($fell(sclk) |-> !sclk [*8])
      else $error("sclk low phase shorter than eight cycles");
   chk_first_rise: assert property ($fell(serial_load_strobe_n) |-> !sclk [*8] ##1 sclk)
      else $error("first sclk rise not eight cycles after strobe fall");
   chk_sdata_hold: assert property (sclk |-> $stable(sdata))
      else $error("sdata moved while sclk high");
   chk_sdata_setup: assert property ($rose(sclk) |-> sdata == $past(sdata, 2))
      else $error("sdata not settled before sclk rise");
   chk_strobe_edge: assert property ($changed(serial_load_strobe_n) |-> !sclk)
      else $error("strobe changed with sclk high");
   chk_frame_bits: assert property ($rose(serial_load_strobe_n) |->
      rises >= 10'h028 && (rises - 10'h028) % 10'h01c == 10'h000)
      else $error("frame not 40 bits plus whole 28-bit words");

   cover property ($rose(serial_load_strobe_n) && rises == 10'h028);
   cover property ($rose(serial_load_strobe_n) && rises == 10'h060);
   cover property ($rose(sclk) && !serial_load_strobe_n);
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        host_rst_n = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        vertical_sync = 1'b0;
   logic        horizontal_sync = 1'b0;
   logic        sensor_gate = 1'b0;
   logic        sequence_change_position = 1'b0;
   logic [7:0]  scp_sequence = 8'h00;
   logic [7:0]  scp_pattern_group = 8'h00;
   logic [11:0] rd_addr = 12'h000;
   logic        rd_strobe = 1'b0;
   logic [27:0] rd_data;
   logic        frame_written;
   logic        frame_discarded;
   logic        commit_busy;
   int          errors = 0;
   int          n_compared = 0;
   int          fw_cnt = 0;
   int          disc_cnt = 0;
   int          cycles = 0;
   logic [27:0] r [0:15];
   logic [27:0] q [$];
   logic [11:0] pa, sa, fa;
   int          n, d;

   serial_link_if serial_link_if_inst ();
   serial_host serial_host_inst (.clk(clk), .rst_n(host_rst_n), .link(serial_link_if_inst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   serial_device serial_device_inst (.clk(clk), .rst_n(rst_n), .link(serial_link_if_inst),
      .vertical_sync(vertical_sync), .horizontal_sync(horizontal_sync),
      .sensor_gate(sensor_gate), .sequence_change_position(sequence_change_position),
      .scp_sequence(scp_sequence), .scp_pattern_group(scp_pattern_group),
      .rd_addr(rd_addr), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .frame_written(frame_written), .frame_discarded(frame_discarded),
      .commit_busy(commit_busy));
   // host reset is separate so a frame can be cut short on purpose
   serial_link_checker serial_link_checker_inst (.clk(clk), .rst_n(host_rst_n),
      .sclk(serial_link_if_inst.sclk), .sdata(serial_link_if_inst.sdata),
      .serial_load_strobe_n(serial_link_if_inst.serial_load_strobe_n));

   always #10 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (frame_written === 1'b1) fw_cnt <= fw_cnt + 1;
      if (frame_discarded === 1'b1) disc_cnt <= disc_cnt + 1;
      if (cycles == 90000) begin
         errors = errors + 1;
         $display("[ERR] %0t run too long", $time);
         finish_test();
      end
   end

   function automatic logic [11:0] seq_base(input logic [7:0] pg);
      return serial_pkg::TABLE_BASE + 12'(pg) * serial_pkg::PG_SIZE;
   endfunction
   function automatic logic [11:0] field_base(input logic [7:0] pg, input logic [7:0] sq);
      return seq_base(pg) + 12'(sq) * serial_pkg::SEQ_SIZE;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task hw(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task hr(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // one address then whole words; each 28-bit word is padded to 32 bits and the host keeps bits 27:0
   task burst(input logic [11:0] a, input logic [27:0] w [$]);
      int          m;
      logic [31:0] s;
      hw(serial_pkg::HOST_ADDR_REG, {20'h0, a});
      foreach (w[i]) begin
         m = fw_cnt;
         hw(serial_pkg::HOST_DATA_REG, {4'h0, w[i]});
         if (i == w.size() - 1) hw(serial_pkg::HOST_CTRL_REG, 32'h1);
         for (int k = 0; k < 1000 && fw_cnt == m; k++) @(posedge clk);
         for (int k = 0; k < 100; k++) begin
            hr(serial_pkg::HOST_STATUS_REG, s);
            if (s[0] === 1'b0 && (i < w.size() - 1 || s[1] === 1'b0)) break;
         end
      end
   endtask

   task wait_commit;
      for (int k = 0; k < 10 && commit_busy !== 1'b1; k++) @(posedge clk);
      for (int k = 0; k < 5000 && commit_busy !== 1'b0; k++) @(posedge clk);
   endtask

   task check(input logic [11:0] a, input logic [27:0] e);
      logic [27:0] v;
      @(posedge clk);
      rd_addr   <= a;
      rd_strobe <= 1'b1;
      @(posedge clk);
      rd_strobe <= 1'b0;
      #1 v = rd_data;
      n_compared++;
      if (v !== e) begin
         errors++;
         $display("[ERR] %0t reg %h read %h expected %h", $time, a, v, e);
      end
   endtask

   task cmp_cnt(input int got, input int e);
      n_compared++;
      if (got != e) begin
         errors++;
         $display("[ERR] %0t count %0d expected %0d", $time, got, e);
      end
   endtask

   // sync pulses are two cycles wide, the sequence change pulse one; a sync commit follows the sync's falling edge
   task pulse(input int kind, input logic [7:0] sq, input logic [7:0] pg, input logic g);
      @(posedge clk);
      scp_sequence      <= sq;
      scp_pattern_group <= pg;
      sensor_gate       <= g;
      if (kind == 0) vertical_sync <= 1'b1;
      if (kind == 1) horizontal_sync <= 1'b1;
      if (kind == 2) sequence_change_position <= 1'b1;
      @(posedge clk);
      sequence_change_position <= 1'b0;
      @(posedge clk);
      vertical_sync   <= 1'b0;
      horizontal_sync <= 1'b0;
      sensor_gate     <= 1'b0;
      wait_commit();
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'ha02e67fe));
      for (int i = 0; i < 16; i++) r[i] = 28'($urandom);
      repeat (20) @(posedge clk);
      rst_n      <= 1'b1;
      host_rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         q = {r[i]};
         burst(12'(i), q);
         check(12'(i), r[i]);
      end
      q = {28'hfffffff, 28'h0000001, 28'h8000000};
      burst(12'h001, q);
      check(12'h001, 28'hfffffff);
      check(12'h002, 28'h0000001);
      check(12'h003, 28'h8000000);
      q = {28'h0000001, 28'h0000001};
      burst(serial_pkg::PG_COUNT_ADDR, q);
      check(serial_pkg::SEQ_COUNT_ADDR, 28'h0000001);
      pa = seq_base(8'h01) - 12'h001;
      sa = field_base(8'h01, 8'h01) - 12'h001;
      fa = field_base(8'h01, 8'h01);
      q = {r[4]};
      burst(pa, q);
      q = {r[5]};
      burst(sa, q);
      q = {r[6]};
      burst(fa, q);
      pulse(0, 8'h00, 8'h00, 1'b0);
      check(fa, r[6]);
      pulse(2, 8'h00, 8'h00, 1'b0);
      check(pa, r[4]);
      check(sa, r[5]);
      for (int i = 7; i < 11; i++) begin
         q = {r[i]};
         burst(i < 9 ? fa : (i == 9 ? sa : pa), q);
      end
      check(fa, r[6]);
      pulse(0, 8'h00, 8'h00, 1'b0);
      check(fa, r[8]);
      check(sa, r[5]);
      pulse(2, 8'h01, 8'h01, 1'b0);
      check(pa, r[4]);
      pulse(2, 8'h00, 8'h00, 1'b0);
      check(sa, r[9]);
      check(pa, r[10]);
      q = {r[13]};
      burst(12'h004, q);
      pulse(0, 8'h00, 8'h00, 1'b0);
      check(12'h004, r[13]);
      q = {28'h0000001};
      burst(serial_pkg::LINE_DELAY_ADDR, q);
      pulse(0, 8'h00, 8'h00, 1'b0);
      q = {r[14]};
      burst(12'h004, q);
      pulse(0, 8'h00, 8'h00, 1'b0);
      check(12'h004, r[13]);
      pulse(1, 8'h00, 8'h00, 1'b0);
      check(12'h004, r[14]);
      q = {r[11]};
      burst(serial_pkg::SG_FIRST, q);
      pulse(1, 8'h00, 8'h00, 1'b1);
      check(serial_pkg::SG_FIRST, r[11]);
      q = {r[12]};
      burst(serial_pkg::SG_FIRST, q);
      pulse(1, 8'h00, 8'h00, 1'b0);
      check(serial_pkg::SG_FIRST, r[11]);
      pulse(1, 8'h00, 8'h00, 1'b1);
      check(serial_pkg::SG_FIRST, r[12]);
      // cut the host off in mid data word: the word must be dropped
      n = fw_cnt;
      d = disc_cnt;
      hw(serial_pkg::HOST_ADDR_REG, 32'h0);
      hw(serial_pkg::HOST_DATA_REG, {4'h0, ~r[0]});
      repeat (400) @(posedge clk);
      host_rst_n <= 1'b0;
      @(posedge clk);
      host_rst_n <= 1'b1;
      repeat (10) @(posedge clk);
      cmp_cnt(disc_cnt - d, 1);
      cmp_cnt(fw_cnt - n, 0);
      check(12'h000, r[0]);
      finish_test();
   end
endmodule
`default_nettype wire
